//--- hdl/lpoeb_defines.vh
// constants for the led page output enable bank
// Operation
// - page a holds per-module enable per line
// - page b holds independent enable set
// - disabled module skips offset and writeback
// - enables act only in automatic mode
// - five-module low register top bits zero
// - low bit k module k, high 8+k
// - page select sampled after each frame
// - auto enable bit selects automatic mode
// - eight common lines, eight sets per page
`ifndef LPOEB_DEFINES_VH
`define LPOEB_DEFINES_VH
// byte addresses of the register groups
`define LPOEB_PAGE_A_BASE  12'h000
`define LPOEB_PAGE_B_BASE  12'h040
`define LPOEB_CTRL_ADDR    12'h080
`define LPOEB_STAT_ADDR    12'h084
// control field positions
`define LPOEB_CTRL_PSEL    0
`define LPOEB_CTRL_AUTO    1
// status field positions
`define LPOEB_STAT_PAGE    0
`define LPOEB_STAT_AUTO    1
`define LPOEB_STAT_COM_LO  4
// reset values
`define LPOEB_EN_RESET     8'h00
`define LPOEB_CTRL_RESET   1'b0
// sizes
`define LPOEB_COM_LINES    8
`define LPOEB_MAX_MODULES  16
`endif

//--- hdl/lpoeb_gate.v
// output gating stage: pwm, offset update and writeback enables
module lpoeb_gate (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        auto_en,
  input  wire [15:0] en_set,
  input  wire [15:0] pwm_in,
  output reg  [15:0] pwm_out,
  output reg  [15:0] offset_upd_en,
  output reg  [15:0] ram_wb_en
);

  // registered gating; manual mode passes everything untouched
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwm_out       <= 16'h0000;
      offset_upd_en <= 16'h0000;
      ram_wb_en     <= 16'h0000;
    end
    else if (ce)
    begin
      if (auto_en)
      begin
        // automatic mode: set m of the active page gates each module
        pwm_out       <= pwm_in & en_set;
        offset_upd_en <= en_set;
        ram_wb_en     <= en_set;
      end
      else
      begin
        // manual mode: enable bits have no say
        pwm_out       <= pwm_in;
        offset_upd_en <= 16'hffff;
        ram_wb_en     <= 16'hffff;
      end
    end
  end

endmodule // lpoeb_gate

//--- hdl/lpoeb_top.v
// led page output enable bank with ahb-lite register slave
`include "lpoeb_defines.vh"
module lpoeb_top #(
  parameter MODULES = 16          // variant: 5, 8 or 16 modules
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire        frame_done,
  input  wire [2:0]  com_index,
  input  wire [15:0] pwm_in,
  output wire [15:0] pwm_out,
  output wire [15:0] offset_upd_en,
  output wire [15:0] ram_wb_en,
  output wire        active_page,
  output wire        auto_mode
);
  // byte map: page a set m at 0x000 + 8*m, page b set m at 0x040 + 8*m,
  // the high byte of a set four bytes above its low byte; control at
  // 0x080, read-only status at 0x084
  // hsize and address bits above 11 are not decoded, so the map repeats
  // every 4 kbyte; only whole-word accesses are meant to be used
  // writes cost no wait state, reads one, so a read that follows a
  // write straight away still returns the new value

  // enable storage, one entry per common line
  reg  [7:0]  a_lo_q [0:`LPOEB_COM_LINES-1]; // page a, modules 0..7
  reg  [7:0]  a_hi_q [0:`LPOEB_COM_LINES-1]; // page a, modules 8..f
  reg  [7:0]  b_lo_q [0:`LPOEB_COM_LINES-1]; // page b, modules 0..7
  reg  [7:0]  b_hi_q [0:`LPOEB_COM_LINES-1]; // page b, modules 8..f
  reg         psel_q;                        // software page request
  reg         auto_q;                        // automatic mode enable
  reg         page_q;                        // page in use by hardware
  reg         pend_q;                        // data phase outstanding
  reg         pwr_q;                         // pending access is a write
  reg         rd_wait_q;                     // read wait state
  reg  [11:0] paddr_q;                       // latched byte address
  reg  [31:0] hrdata_q;                      // read data register
  reg  [15:0] en_set_d;                      // selected enable set
  integer     i;                             // reset loop index

  // implemented bits of the low register for this variant
  function [7:0] lo_mask;
    input integer n;
    begin
      if (n < 8)
        lo_mask = 8'h1f;
      else
        lo_mask = 8'hff;
    end
  endfunction

  // implemented bits of the high register for this variant
  function [7:0] hi_mask;
    input integer n;
    begin
      if (n > 8)
        hi_mask = 8'hff;
      else
        hi_mask = 8'h00;
    end
  endfunction

  // address phase accepted only while the clock is enabled
  wire take = hsel & hready & htrans[1] & ce;
  // write lands at the end of its data phase
  wire wr_go = pend_q & pwr_q & ce;
  // line and register select within a page group
  wire [2:0] p_com = paddr_q[5:3];
  wire       p_hi  = paddr_q[2];

  // a frozen block stalls the bus rather than losing a transfer;
  // reads cost one wait state so a prior write is always visible
  assign hreadyout = ce & ~rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign active_page = page_q;
  assign auto_mode   = auto_q;

  // bus phase tracking
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_q    <= 1'b0;
      pwr_q     <= 1'b0;
      rd_wait_q <= 1'b0;
      paddr_q   <= 12'h000;
    end
    else if (ce)
    begin
      if (rd_wait_q)
      begin
        // wait state over, data is ready next cycle
        rd_wait_q <= 1'b0;
      end
      // new address phase; a read also opens its wait state
      else if (take)
      begin
        pend_q    <= 1'b1;
        pwr_q     <= hwrite;
        rd_wait_q <= ~hwrite;
        paddr_q   <= {haddr[11:2], 2'b00};
      end
      else
      begin
        // bus idle: no data phase follows
        pend_q    <= 1'b0;
      end
    end
  end

  // enable register writes
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < `LPOEB_COM_LINES; i = i + 1)
      begin
        a_lo_q[i] <= `LPOEB_EN_RESET;
        a_hi_q[i] <= `LPOEB_EN_RESET;
        b_lo_q[i] <= `LPOEB_EN_RESET;
        b_hi_q[i] <= `LPOEB_EN_RESET;
      end
    end
    // control, status and unmapped writes fall through untouched
    else if (wr_go)
    begin
      if (paddr_q < `LPOEB_PAGE_B_BASE)
      begin
        // page a group, eight line sets
        if (p_hi)
          a_hi_q[p_com] <= hwdata[7:0] & hi_mask(MODULES);
        else
          a_lo_q[p_com] <= hwdata[7:0] & lo_mask(MODULES);
      end
      else if (paddr_q < `LPOEB_CTRL_ADDR)
      begin
        // page b group, independent of page a
        if (p_hi)
          b_hi_q[p_com] <= hwdata[7:0] & hi_mask(MODULES);
        else
          b_lo_q[p_com] <= hwdata[7:0] & lo_mask(MODULES);
      end
    end
  end

  // control register
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      psel_q <= `LPOEB_CTRL_RESET;
      auto_q <= `LPOEB_CTRL_RESET;
    end
    else if (wr_go && paddr_q == `LPOEB_CTRL_ADDR)
    begin
      psel_q <= hwdata[`LPOEB_CTRL_PSEL];
      auto_q <= hwdata[`LPOEB_CTRL_AUTO];
    end
  end

  // page changes only at a frame boundary so a frame never mixes pages
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      page_q <= 1'b0;
    else if (ce && frame_done)
      // a request made mid frame waits for the boundary
      page_q <= psel_q;
  end

  // read data captured during the wait state
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hrdata_q <= 32'h00000000;
    else if (ce && rd_wait_q)
    begin
      if (paddr_q < `LPOEB_PAGE_B_BASE)
        hrdata_q <= {24'h000000, p_hi ? a_hi_q[p_com] : a_lo_q[p_com]};
      else if (paddr_q < `LPOEB_CTRL_ADDR)
        hrdata_q <= {24'h000000, p_hi ? b_hi_q[p_com] : b_lo_q[p_com]};
      else if (paddr_q == `LPOEB_CTRL_ADDR)
        hrdata_q <= {30'h00000000, auto_q, psel_q};
      // status: line index, auto flag, page in use
      else if (paddr_q == `LPOEB_STAT_ADDR)
        hrdata_q <= {25'h0000000, com_index, 2'b00, auto_q, page_q};
      else
        hrdata_q <= 32'h00000000; // unmapped reads zero
    end
  end

  // pick line m of the active page
  always @*
  begin
    if (page_q)
      en_set_d = {b_hi_q[com_index], b_lo_q[com_index]};
    else
      en_set_d = {a_hi_q[com_index], a_lo_q[com_index]};
  end

  // gating stage
  lpoeb_gate u_gate (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .ce            (ce),
    .auto_en       (auto_q),
    .en_set        (en_set_d),
    .pwm_in        (pwm_in),
    .pwm_out       (pwm_out),
    .offset_upd_en (offset_upd_en),
    .ram_wb_en     (ram_wb_en)
  );

endmodule // lpoeb_top

//--- sim/lpoeb_chk_assertions.sv
// port assertions for the led page enable bank
module lpoeb_chk (
  input wire        clk,
  input wire        sys_rst,
  input wire        ce,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        frame_done,
  input wire [15:0] pwm_in,
  input wire [15:0] pwm_out,
  input wire [15:0] offset_upd_en,
  input wire [15:0] ram_wb_en,
  input wire        active_page,
  input wire        auto_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // accepted address phase
  wire take = hsel & hready & htrans[1] & ce;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  read_wait_a: assert property (take && !hwrite |=> !hreadyout)
    else $error("read without wait");
  write_fast_a: assert property (take && hwrite |=> hreadyout == ce)
    else $error("write stalled");
  ready_stall_a: assert property (!ce |-> !hreadyout)
    else $error("ready while frozen");
  output_freeze_a: assert property (!ce |=> $stable(pwm_out))
    else $error("output moved while frozen");
  manual_pass_a: assert property (
    !sys_rst && ce && !auto_mode |=>
      pwm_out == $past(pwm_in) && ram_wb_en == 16'hffff)
    else $error("manual not transparent");
  auto_gate_a: assert property (
    ce && auto_mode |=> pwm_out == ($past(pwm_in) & offset_upd_en))
    else $error("gating wrong");
  wb_equal_a: assert property (ram_wb_en == offset_upd_en)
    else $error("writeback differs");
  page_hold_a: assert property (
    !(frame_done && ce) |=> $stable(active_page))
    else $error("page moved mid frame");
endmodule // lpoeb_chk
bind lpoeb_top lpoeb_chk lpoeb_chk_inst (.clk, .sys_rst, .ce, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .frame_done, .pwm_in, .pwm_out,
  .offset_upd_en, .ram_wb_en, .active_page, .auto_mode);

//--- sim/lpoeb_scan_model.sv
// common-line scanner and segment pattern source
module lpoeb_scan_model (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [2:0]  target,
  input  wire [15:0] pat,
  output logic [2:0] com_index,
  output logic       frame_done,
  output wire [15:0] pwm_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pwm_in = pat;
  // one line a cycle toward target, wrap past 7 ends a frame
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      com_index <= 3'h0;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= com_index != target && com_index == 3'h7;
      if (com_index != target)
        com_index <= com_index + 3'h1;
    end
endmodule // lpoeb_scan_model

//--- sim/lpoeb_top_tb.sv
// self-checking bench for the led page enable bank
`include "lpoeb_defines.vh"
module lpoeb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, sys_rst = 1, ce = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, r, r5;
  logic [15:0] pat = 16'h5a3c, e;
  logic [2:0]  hsize = 3'h2, target = 0;
  logic [1:0]  htrans = 0;
  wire  [31:0] hrdata, hrdata5;
  wire  [15:0] pwm_in, pwm_out, offset_upd_en, ram_wb_en;
  wire  [2:0]  com_index;
  wire         hreadyout, hresp, frame_done, active_page, auto_mode;
  int          mismatches = 0, check_count = 0, cycles = 0, k;
  always #2.5 clk = ~clk;
  lpoeb_top lpoeb_top_inst (.clk, .sys_rst, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .frame_done, .com_index, .pwm_in, .pwm_out, .offset_upd_en,
    .ram_wb_en, .active_page, .auto_mode);
  lpoeb_scan_model lpoeb_scan_model_inst (.clk, .sys_rst, .target, .pat,
    .com_index, .frame_done, .pwm_in);
  // five-module variant on the same bus, read in step with the first
  lpoeb_top #(.MODULES(5)) lpoeb_top_small_inst (.clk, .sys_rst, .ce,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(hrdata5), .frame_done, .com_index,
    .pwm_in, .pwm_out(), .offset_upd_en(), .ram_wb_en(), .active_page(),
    .auto_mode());
  // per line values: both pages distinct, bytes distinct
  function [15:0] ex(input b, input [2:0] m);
    ex = b ? {8'hc0 | m, 8'h30 | m} : {8'h50 | m, 8'ha0 | m};
  endfunction
  task final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // ready is sampled at the edge; negedge view equals it
  task wait_rdy;
    logic ok;
    do
    begin
      @(negedge clk);
      ok = hreadyout;
      r = hrdata;
      r5 = hrdata5;
      @(posedge clk);
    end
    while (ok !== 1'b1);
  endtask
  task xfer(input w, input [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    // the slave only ever answers okay
    chk(hresp, 0);
  endtask
  task rd(input [31:0] a, exp);
    xfer(1'b0, a, 0);
    chk(r, exp);
  endtask
  // scanner walks at most 7 lines, then two pipeline stages
  task go(input [2:0] m);
    @(posedge clk);
    target <= m;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`LPOEB_CTRL_ADDR, 0);
    rd({20'h0, `LPOEB_PAGE_B_BASE} + 32'h3c, 0);
    rd(32'h100, 0);
    $display("test 1 done");
    // fill both pages, junk above the byte must drop
    for (k = 0; k < 32; k++)
    begin
      e = ex(k[4], k[2:0]);
      xfer(1'b1, {25'h0, k[4], k[2:0], k[3], 2'h0},
        {24'hffffff, k[3] ? e[15:8] : e[7:0]});
    end
    for (k = 0; k < 32; k++)
    begin
      e = ex(k[4], k[2:0]);
      rd({25'h0, k[4], k[2:0], k[3], 2'h0}, k[3] ? e[15:8] : e[7:0]);
      // small variant: top three low bits and the high byte read zero
      chk(r5, k[3] ? 32'h0 : {24'h0, e[7:0] & 8'h1f});
    end
    $display("test 2 done");
    chk(pwm_out, pat);
    chk(ram_wb_en, 16'hffff);
    xfer(1'b1, `LPOEB_CTRL_ADDR, 2);
    for (k = 0; k < 8; k++)
    begin
      go(k[2:0]);
      chk(offset_upd_en, ex(0, k[2:0]));
      chk(pwm_out, pat & ex(0, k[2:0]));
    end
    $display("test 3 done");
    xfer(1'b1, `LPOEB_CTRL_ADDR, 3);
    go(3'h7);
    chk(active_page, 0);
    go(3'h0);
    chk(active_page, 1);
    for (k = 0; k < 8; k++)
    begin
      go(k[2:0]);
      chk(ram_wb_en, ex(1, k[2:0]));
    end
    xfer(1'b1, `LPOEB_STAT_ADDR, 0);
    rd(`LPOEB_STAT_ADDR, 32'h73);
    xfer(1'b1, `LPOEB_CTRL_ADDR, 1);
    go(3'h2);
    chk(offset_upd_en, 16'hffff);
    $display("test 4 done");
    // freeze: outputs, page and bus hold while the scanner runs on
    xfer(1'b1, `LPOEB_CTRL_ADDR, 2);
    go(3'h5);
    e = pat & ex(1, 3'h5);
    chk(pwm_out, e);
    @(posedge clk);
    ce <= 1'b0;
    target <= 3'h1;
    pat <= 16'hffff;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk(hreadyout, 0);
    chk(pwm_out, e);
    chk(offset_upd_en, ex(1, 3'h5));
    chk(active_page, 1);
    @(posedge clk);
    ce <= 1'b1;
    go(3'h1);
    chk(pwm_out, pat & ex(1, 3'h1));
    go(3'h0);
    chk(active_page, 0);
    chk(ram_wb_en, ex(0, 3'h0));
    $display("test 5 done");
    final_report();
  end
endmodule // lpoeb_top_tb
